/* File: pkg/dfl_defines.svh */
// Purpose: constants of the decode fusion block
// Assumes: included by the package and the design
// Notes: no processes here
`ifndef DFL_DEFINES_SVH
`define DFL_DEFINES_SVH
`define DFL_GRP_N 5
`define DFL_DEC_N 4
`define DFL_PEAK_INSN 4'h5
`define DFL_OPND_W 16
`define DFL_FIFO_D 16
`define DFL_LOOP_MAX 5'h10
`define DFL_CC_B 4'h2
`define DFL_CC_AE 4'h3
`define DFL_CC_E 4'h4
`define DFL_CC_NE 4'h5
`define DFL_CC_BE 4'h6
`define DFL_CC_A 4'h7
`endif

/* File: pkg/dfl_pkg.sv */
// Purpose: types of the decode fusion block
// Assumes: dfl_defines.svh on the include path
// Notes: one slot is one predecoded instruction
`include "dfl_defines.svh"
package dfl_pkg;
   typedef enum logic [2:0] {
      CL_OTHER = 3'h0, CL_CMP = 3'h1, CL_TEST = 3'h2, CL_JCC = 3'h3,
      CL_STORE = 3'h4, CL_LOADOP = 3'h5, CL_LOADJMP = 3'h6
   } dfl_cls_e;
   typedef enum logic [2:0] {
      FM_RR = 3'h0, FM_RI = 3'h1, FM_RM = 3'h2, FM_MR = 3'h3,
      FM_MI = 3'h4
   } dfl_form_e;
   typedef enum logic [1:0] {
      UK_SINGLE = 2'h0, UK_FUSED = 2'h1, UK_TWOFLOW = 2'h2
   } dfl_kind_e;
   typedef struct packed {
      dfl_cls_e cls;
      dfl_form_e form;
      logic [3:0] cond;
      logic ip_rel;
      logic has_imm;
      logic ip_ctrl;
      logic loop_br;
      logic [`DFL_OPND_W-1:0] opnd;
      logic [`DFL_OPND_W-1:0] target;
   } dfl_insn_s;
   typedef struct packed {
      logic [`DFL_GRP_N-1:0] vld;
      dfl_insn_s [`DFL_GRP_N-1:0] slot;
   } dfl_grp_s;
   typedef struct packed {
      dfl_kind_e kind;
      dfl_cls_e cls;
      dfl_form_e form;
      logic [3:0] cond;
      logic [`DFL_OPND_W-1:0] opnd;
      logic [`DFL_OPND_W-1:0] target;
      logic ufused;
      logic sta_std;
      logic [1:0] n_insn;
      logic misp_save;
      logic is_br;
      logic pred_taken;
   } dfl_uop_s;
endpackage

/* File: hw/dfl_decode.sv */
// Purpose: fusion-aware decode of predecoded instruction groups
// Assumes: one clock, groups arrive in program order
// Notes: holds the group FIFO and the four-decoder stage
`timescale 1ns/10ps
`default_nettype none
`include "dfl_defines.svh"

////////////////////////////////////////////////////////////////////////
module dfl_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clk, // clock
   input wire logic rst_n, // async reset
   input wire logic in_valid, // write request
   output logic in_ready, // room left
   input wire logic [W-1:0] in_data, // write word
   output logic out_valid, // word waiting
   input wire logic out_ready, // drain side takes
   output logic [W-1:0] out_data // head word
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_r, rp_r;
   logic [AW:0] cnt_r;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_r != (AW+1)'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   always_ff @(posedge clk) begin
      if (push) mem[wp_r] <= in_data;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) wp_r <= AW'(wp_r + 1'b1);
         if (pop) rp_r <= AW'(rp_r + 1'b1);
         cnt_r <= (AW+1)'(cnt_r + push - pop);
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////
module dfl_decode import dfl_pkg::*; #(
   parameter int FIFO_D = `DFL_FIFO_D
) (
   input wire logic REF_CLK, // core clock
   input wire logic NRST, // async reset, low
   input wire logic GRP_VALID, // group offered
   output logic GRP_READY, // group taken
   input wire dfl_grp_s GRP, // predecoded group
   input wire logic MODE_64, // 64-bit execution mode
   output logic [`DFL_DEC_N-1:0] UOP_VALID, // entry valid per decoder
   output dfl_uop_s [`DFL_DEC_N-1:0] UOP, // decoded entries
   input wire logic UOP_READY, // downstream accepts
   input wire logic RES_VALID, // branch resolved
   input wire logic RES_LOOP, // resolved one was loop branch
   input wire logic RES_TAKEN // resolved direction
);
   localparam int GN = `DFL_GRP_N;
   localparam int DN = `DFL_DEC_N;

   function automatic logic f_cc_flag(input logic [3:0] c);
      return c == `DFL_CC_A || c == `DFL_CC_AE || c == `DFL_CC_E ||
             c == `DFL_CC_BE || c == `DFL_CC_B || c == `DFL_CC_NE;
   endfunction

   function automatic logic f_pair(input dfl_insn_s a, input dfl_insn_s b,
                                   input logic m64);
      logic first_ok;
      first_ok = (a.cls == CL_CMP) || (a.cls == CL_TEST);
      return !m64 && first_ok && b.cls == CL_JCC && a.form != FM_MI &&
             (a.cls == CL_TEST || f_cc_flag(b.cond));
   endfunction

   function automatic logic f_rip_split(input dfl_insn_s a);
      return a.ip_rel && (a.has_imm || a.ip_ctrl);
   endfunction

   function automatic logic f_ufuse(input dfl_insn_s a);
      logic memf;
      memf = a.cls == CL_STORE || a.cls == CL_LOADOP ||
             a.cls == CL_LOADJMP ||
             ((a.cls == CL_CMP || a.cls == CL_TEST) && a.form == FM_MI);
      return memf && !f_rip_split(a);
   endfunction

   function automatic dfl_uop_s f_entry(input dfl_insn_s a);
      dfl_uop_s u;
      u = '0;
      u.kind = f_rip_split(a) ? UK_TWOFLOW : UK_SINGLE;
      u.cls = a.cls;
      u.form = a.form;
      u.cond = a.cond;
      u.opnd = a.opnd;
      u.target = a.target;
      u.ufused = f_ufuse(a);
      // store split into address and data
      u.sta_std = a.cls == CL_STORE;
      u.n_insn = 2'h1;
      u.is_br = a.cls == CL_JCC;
      return u;
   endfunction

   ////////////////////////////////////////////////////////////////////
   dfl_grp_s fifo_q, g_r;
   logic fifo_v, fifo_pop;
   logic [GN-1:0] vld_r;
   logic [2:0] pos_r, pos_nxt;
   logic [DN-1:0] uop_v_r;
   dfl_uop_s [DN-1:0] uop_r;
   logic [DN-1:0] dec_v;
   dfl_uop_s [DN-1:0] dec;
   logic [3:0] n_sum;
   logic [1:0] f_sum;
   logic br_seen, br_loop, br_pred;
   logic [4:0] iter_r, trip_r, cnt_r;
   logic learn_r, body_r, alt_r;

   dfl_fifo #(.W($bits(dfl_grp_s)), .D(FIFO_D)) u_fifo (
      .clk(REF_CLK),
      .rst_n(NRST),
      .in_valid(GRP_VALID),
      .in_ready(GRP_READY),
      .in_data(GRP),
      .out_valid(fifo_v),
      .out_ready(fifo_pop),
      .out_data(fifo_q)
   );

   // output stage stalls until downstream takes the whole row
   wire adv = UOP_READY || (uop_v_r == '0);
   wire [GN-1:0] rest = vld_r >> pos_nxt;
   assign fifo_pop = adv && (rest == '0);
   wire exit_pred = learn_r && (5'(iter_r + 5'h1) == trip_r);

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [2:0] p;
      logic stop;
      dfl_insn_s i0, i1;
      logic v1;
      p = pos_r;
      stop = !adv;
      n_sum = 4'h0;
      f_sum = 2'h0;
      br_seen = 1'b0;
      br_loop = 1'b0;
      br_pred = 1'b0;
      i0 = '0;
      i1 = '0;
      v1 = 1'b0;
      for (int d = 0; d < DN; d++) begin
         dec_v[d] = 1'b0;
         dec[d] = '0;
         if (!stop && p < 3'(GN) && vld_r[p]) begin
            i0 = g_r.slot[p];
            v1 = (p < 3'(GN - 1)) && vld_r[3'(p + 3'h1)];
            i1 = v1 ? g_r.slot[3'(p + 3'h1)] : '0;
            // two-operation flow only from decoder 0
            if (f_rip_split(i0) && d != 0) begin
               stop = 1'b1;
            // at most one fused pair per cycle
            end else if (v1 && f_sum == 2'h0 && f_pair(i0, i1, MODE_64)) begin
               // one entry for both, cond and target taken from the jump
               dec_v[d] = 1'b1;
               dec[d] = f_entry(i0);
               dec[d].kind = UK_FUSED;
               dec[d].cond = i1.cond;
               dec[d].target = i1.target;
               dec[d].n_insn = 2'h2;
               dec[d].misp_save = 1'b1;
               dec[d].is_br = 1'b1;
               i0 = i1;
               p = 3'(p + 3'h2);
               f_sum = 2'h1;
            end else begin
               dec_v[d] = 1'b1;
               dec[d] = f_entry(i0);
               p = 3'(p + 3'h1);
            end
            if (dec_v[d]) begin
               n_sum = 4'(n_sum + {2'h0, dec[d].n_insn});
               if (dec[d].is_br) begin
                  br_seen = 1'b1;
                  br_loop = i0.loop_br;
                  br_pred = i0.loop_br ? !exit_pred : !alt_r;
                  dec[d].pred_taken = br_pred;
                  stop = 1'b1;
               end
            end
         end
      end
      pos_nxt = p;
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         g_r <= '0;
         vld_r <= '0;
         pos_r <= 3'h0;
         uop_v_r <= '0;
         uop_r <= '0;
      end else if (adv) begin
         uop_v_r <= dec_v;
         uop_r <= dec;
         if (fifo_pop) begin
            g_r <= fifo_q;
            vld_r <= fifo_v ? fifo_q.vld : '0;
            pos_r <= 3'h0;
         end else begin
            pos_r <= pos_nxt;
         end
      end
   end
   assign UOP_VALID = uop_v_r;
   assign UOP = uop_r;

   // loop predictor: speculative count at decode, trained at resolve
   always_ff @(posedge REF_CLK or negedge NRST) begin
      if (!NRST) begin
         iter_r <= 5'h0;
         trip_r <= 5'h0;
         cnt_r <= 5'h0;
         learn_r <= 1'b0;
         body_r <= 1'b0;
         alt_r <= 1'b0;
      end else begin
         if (br_seen && br_loop) begin
            iter_r <= br_pred ? 5'(iter_r + 5'h1) : 5'h0;
         end
         if (RES_VALID && !RES_LOOP) begin
            body_r <= 1'b1;
            alt_r <= RES_TAKEN;
         end
         if (RES_VALID && RES_LOOP && RES_TAKEN) begin
            cnt_r <= (cnt_r == 5'h1F) ? cnt_r : 5'(cnt_r + 5'h1);
         end else if (RES_VALID && RES_LOOP) begin
            // learn trip only for short loops without body branches
            learn_r <= (cnt_r < `DFL_LOOP_MAX) && !body_r;
            trip_r <= 5'(cnt_r + 5'h1);
            cnt_r <= 5'h0;
            body_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!NRST);

   sequence s_stall;
      (UOP_VALID != '0) && !UOP_READY;
   endsequence
   sequence s_hold;
      $stable(UOP_VALID) && $stable(UOP);
   endsequence

   chk_first_pair: assert property (
      adv && pos_r < 3'(GN - 1) && vld_r[pos_r] &&
      vld_r[3'(pos_r + 3'h1)] && !f_rip_split(g_r.slot[pos_r]) &&
      f_pair(g_r.slot[pos_r], g_r.slot[3'(pos_r + 3'h1)], MODE_64)
      |=> UOP_VALID[0] && UOP[0].kind == UK_FUSED)
      else $error("qualifying pair not fused");
   chk_no_mi_fuse: assert property (
      UOP_VALID[0] && UOP[0].kind == UK_FUSED |-> UOP[0].form != FM_MI)
      else $error("memory-immediate pair fused");
   chk_cmp_cond: assert property (
      dec_v[0] && dec[0].kind == UK_FUSED && dec[0].cls == CL_CMP
      |-> f_cc_flag(dec[0].cond))
      else $error("compare fused with wrong condition");
   chk_mode64_off: assert property (
      MODE_64 |-> !(dec_v[0] && dec[0].kind == UK_FUSED) && f_sum == 2'h0)
      else $error("fusion in 64-bit mode");
   chk_peak_bw: assert property (
      n_sum <= `DFL_PEAK_INSN && f_sum <= 2'h1)
      else $error("decode bandwidth exceeded");
   chk_fused_once: assert property (
      dec_v[1] && dec[1].kind == UK_FUSED
      |-> dec[1].n_insn == 2'h2 && dec[1].misp_save)
      else $error("fused entry not single dispatch");
   chk_store_split: assert property (
      UOP_VALID[2] && UOP[2].cls == CL_STORE |-> UOP[2].sta_std)
      else $error("store not split");
   chk_twoflow_dec0: assert property (
      !(dec_v[1] && dec[1].kind == UK_TWOFLOW) &&
      !(dec_v[2] && dec[2].kind == UK_TWOFLOW) &&
      !(dec_v[3] && dec[3].kind == UK_TWOFLOW))
      else $error("two-operation flow off decoder 0");
   chk_trip_limit: assert property (
      $rose(learn_r) |-> trip_r <= 5'(`DFL_LOOP_MAX))
      else $error("loop trip above limit learned");
   chk_out_hold: assert property (
      s_stall |=> s_hold)
      else $error("output changed while stalled");
endmodule
`default_nettype wire

/* File: verification/dfl_rename_model.sv */
// Purpose: rename side model that takes decoded rows
// Assumes: changes ready only at the falling edge of clk
// Notes: slow mode takes a row every other cycle only
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module dfl_rename_model (
   input wire logic clk, // core clock
   input wire logic rst_n, // async reset, low
   input wire logic stall, // hold off all rows
   input wire logic slow, // take every other cycle
   output logic ready // row taken this edge
);
   logic ph_r = 1'b0;
   // never ready in reset, so no row is lost while it is held
   // combinational, so a stall set at this edge counts at once
   assign ready = rst_n && !stall && (!slow || ph_r);
   always @(negedge clk) begin
      ph_r = ~ph_r;
   end
endmodule
`default_nettype wire

/* File: verification/dfl_decode_tb.sv */
// Purpose: self-checking bench of the fusion decoder
// Assumes: inputs change at the falling clock edge
// Notes: loop predictor trained through the resolve inputs
`timescale 1ns/10ps
`default_nettype none
`include "dfl_defines.svh"

////////////////////////////////////////////////////////////////////////
module dfl_decode_tb import dfl_pkg::*; ;
   logic REF_CLK, NRST, GRP_VALID, GRP_READY, MODE_64, UOP_READY;
   logic stall, slow, RES_VALID, RES_LOOP, RES_TAKEN;
   dfl_grp_s GRP, g;
   logic [`DFL_DEC_N-1:0] UOP_VALID, rv;
   dfl_uop_s [`DFL_DEC_N-1:0] UOP, ru;
   logic [`DFL_DEC_N-1:0] vq[$];
   dfl_uop_s [`DFL_DEC_N-1:0] uq[$];
   int fails = 0;
   int n_tests = 0;
   int cyc = 0;

   dfl_decode #(.FIFO_D(16)) u_dut (.REF_CLK(REF_CLK), .NRST(NRST),
      .GRP_VALID(GRP_VALID), .GRP_READY(GRP_READY), .GRP(GRP),
      .MODE_64(MODE_64), .UOP_VALID(UOP_VALID), .UOP(UOP),
      .UOP_READY(UOP_READY), .RES_VALID(RES_VALID), .RES_LOOP(RES_LOOP),
      .RES_TAKEN(RES_TAKEN));
   dfl_rename_model u_ren (.clk(REF_CLK), .rst_n(NRST), .stall(stall),
      .slow(slow), .ready(UOP_READY));

   initial begin
      REF_CLK = 1'b0;
      forever #50 REF_CLK = ~REF_CLK;
   end

   // rows taken at an edge are the values before that edge's update
   always @(posedge REF_CLK) begin
      cyc++;
      if (NRST && UOP_VALID != 0 && UOP_READY) begin
         vq.push_back(UOP_VALID);
         uq.push_back(UOP);
      end
      if (cyc == 5000) begin
         fails++;
         close_out();
      end
   end

////////////////////////////////////////////////////////////////////////
   task close_out();
      $display("tests %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e) begin
         $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
         fails++;
      end
   endtask

   function automatic dfl_insn_s ins(dfl_cls_e c, dfl_form_e f,
      logic [3:0] cd, logic [15:0] op);
      ins = '0;
      ins.cls = c;
      ins.form = f;
      ins.cond = cd;
      ins.opnd = op;
      ins.target = ~op;
   endfunction

   task put(input int i, input dfl_insn_s x);
      g.vld[i] = 1'b1;
      g.slot[i] = x;
   endtask

   task send();
      int k;
      k = 0;
      @(negedge REF_CLK);
      GRP = g;
      GRP_VALID = 1'b1;
      #1;
      while (GRP_READY !== 1'b1 && k < 200) begin
         @(negedge REF_CLK);
         #1;
         k++;
      end
      @(posedge REF_CLK);
   endtask

   task get_row();
      int k;
      k = 0;
      while (vq.size() == 0 && k < 60) begin
         @(negedge REF_CLK);
         k++;
      end
      rv = '0;
      ru = '0;
      if (vq.size() == 0)
         chk("row arrival", 1, 0);
      else begin
         rv = vq.pop_front();
         ru = uq.pop_front();
      end
   endtask

   // leftover rows of the last group are dropped before the next one
   task run();
      repeat (8) @(negedge REF_CLK);
      vq.delete();
      uq.delete();
      send();
      @(negedge REF_CLK);
      GRP_VALID = 1'b0;
      get_row();
   endtask

////////////////////////////////////////////////////////////////////////
   task t_forms();
      for (int i = 0; i < 5; i++) begin
         g = '0;
         put(0, ins(CL_CMP, dfl_form_e'(i), `DFL_CC_E, 16'h1230 + i));
         put(1, ins(CL_JCC, FM_RR, `DFL_CC_E, 16'hA5A5));
         run();
         if (i != FM_MI) begin
            chk("fused valid", 4'h1, rv);
            chk("fused kind", UK_FUSED, ru[0].kind);
            chk("fused insns", 2'h2, ru[0].n_insn);
            chk("fused opnd", 16'h1230 + i, ru[0].opnd);
            chk("fused target", 16'h5A5A, ru[0].target);
            chk("fused cond", `DFL_CC_E, ru[0].cond);
            chk("misp save", 1'b1, ru[0].misp_save);
         end else begin
            chk("mem imm kind", UK_SINGLE, ru[0].kind);
            chk("mem imm ufused", 1'b1, ru[0].ufused);
         end
      end
      g = '0;
      put(0, ins(CL_CMP, FM_RR, `DFL_CC_E, 16'h0011));
      put(1, ins(CL_OTHER, FM_RR, 4'h0, 16'h0022));
      put(2, ins(CL_JCC, FM_RR, `DFL_CC_E, 16'h0033));
      run();
      chk("gap kind", UK_SINGLE, ru[0].kind);
      chk("gap insns", 2'h1, ru[0].n_insn);
   endtask

   task t_cond();
      logic fz;
      for (int c = 0; c < 2; c++)
         for (int k = 0; k < 16; k++) begin
            g = '0;
            put(0, ins(c ? CL_CMP : CL_TEST, FM_RI, 4'(k), 16'h0042));
            put(1, ins(CL_JCC, FM_RR, 4'(k), 16'h0F0F));
            run();
            fz = c == 0 || (k >= `DFL_CC_B && k <= `DFL_CC_A);
            chk("cond kind", fz ? UK_FUSED : UK_SINGLE, ru[0].kind);
         end
   endtask

   task t_mode64();
      @(negedge REF_CLK);
      MODE_64 = 1'b1;
      for (int c = 0; c < 2; c++) begin
         g = '0;
         put(0, ins(c ? CL_CMP : CL_TEST, FM_RR, `DFL_CC_E, 16'h0077));
         put(1, ins(CL_JCC, FM_RR, `DFL_CC_E, 16'h0088));
         run();
         chk("wide mode kind", UK_SINGLE, ru[0].kind);
      end
      @(negedge REF_CLK);
      MODE_64 = 1'b0;
   endtask

   task t_peak();
      g = '0;
      for (int i = 0; i < 3; i++)
         put(i, ins(CL_OTHER, FM_RR, 4'h0, 16'h0100 + i));
      put(3, ins(CL_CMP, FM_RM, `DFL_CC_NE, 16'h0200));
      put(4, ins(CL_JCC, FM_RR, `DFL_CC_NE, 16'h0300));
      run();
      chk("peak valid", 4'hF, rv);
      chk("peak kind", UK_FUSED, ru[3].kind);
      chk("peak insns", `DFL_PEAK_INSN, ru[0].n_insn + ru[1].n_insn +
         ru[2].n_insn + ru[3].n_insn);
   endtask

   task t_ufuse();
      g = '0;
      put(0, ins(CL_STORE, FM_MI, 4'h0, 16'h0400));
      put(1, ins(CL_LOADOP, FM_RM, 4'h0, 16'h0500));
      put(2, ins(CL_CMP, FM_MI, 4'h0, 16'h0600));
      put(3, ins(CL_LOADJMP, FM_RM, 4'h0, 16'h0700));
      run();
      chk("ufuse valid", 4'hF, rv);
      for (int i = 0; i < 4; i++)
         chk("ufused", 1'b1, ru[i].ufused);
      chk("store split", 1'b1, ru[0].sta_std);
   endtask

   task t_twoflow();
      dfl_insn_s x;
      g = '0;
      put(0, ins(CL_OTHER, FM_RR, 4'h0, 16'h0800));
      x = ins(CL_STORE, FM_MI, 4'h0, 16'h0900);
      x.ip_rel = 1'b1;
      x.has_imm = 1'b1;
      put(1, x);
      x = ins(CL_LOADJMP, FM_RM, 4'h0, 16'h0A00);
      x.ip_rel = 1'b1;
      x.ip_ctrl = 1'b1;
      put(2, x);
      run();
      chk("lead valid", 4'h1, rv);
      for (int i = 0; i < 2; i++) begin
         get_row();
         chk("flow valid", 4'h1, rv);
         chk("flow kind", UK_TWOFLOW, ru[0].kind);
         chk("flow ufused", 1'b0, ru[0].ufused);
      end
   endtask

   // one resolution pulse, sampled at the next rising edge
   task res(input logic lp, input logic tk);
      @(negedge REF_CLK);
      RES_VALID = 1'b1;
      RES_LOOP = lp;
      RES_TAKEN = tk;
      @(negedge REF_CLK);
      RES_VALID = 1'b0;
   endtask

   task br(input logic lp);
      dfl_insn_s x;
      g = '0;
      x = ins(CL_JCC, FM_RR, `DFL_CC_E, 16'h0C00);
      x.loop_br = lp;
      put(0, x);
      run();
   endtask

   // trip of 16 learned, body alternation, body branch blocks learning
   task t_loop();
      repeat (15) res(1'b1, 1'b1);
      res(1'b1, 1'b0);
      for (int i = 0; i < 16; i++) begin
         br(1'b1);
         chk("loop exit", i != 15, ru[0].pred_taken);
      end
      res(1'b0, 1'b1);
      br(1'b0);
      chk("body after taken", 1'b0, ru[0].pred_taken);
      res(1'b0, 1'b0);
      br(1'b0);
      chk("body after not", 1'b1, ru[0].pred_taken);
      res(1'b1, 1'b0);
      br(1'b1);
      chk("no learn body", 1'b1, ru[0].pred_taken);
   endtask

   // the far side stalls so the buffer must refuse, then drains slowly
   task t_fill();
      int n, got, k;
      n = 0;
      got = 0;
      k = 0;
      g = '0;
      put(0, ins(CL_OTHER, FM_RR, 4'h0, 16'h0B00));
      @(negedge REF_CLK);
      stall = 1'b1;
      GRP = g;
      GRP_VALID = 1'b1;
      repeat (30) begin
         #1;
         if (GRP_READY === 1'b1)
            n++;
         @(negedge REF_CLK);
      end
      GRP_VALID = 1'b0;
      chk("full refuses", 1'b0, GRP_READY);
      chk("fill count", 1, n >= 16 && n <= 18);
      stall = 1'b0;
      slow = 1'b1;
      while (got < n && k < 400) begin
         @(negedge REF_CLK);
         while (vq.size() > 0) begin
            got += $countones(vq.pop_front());
            void'(uq.pop_front());
         end
         k++;
      end
      chk("drained", n, got);
      chk("empty ready", 1'b1, GRP_READY);
      slow = 1'b0;
   endtask

////////////////////////////////////////////////////////////////////////
   initial begin
      NRST = 1'b0;
      GRP_VALID = 1'b0;
      GRP = '0;
      g = '0;
      MODE_64 = 1'b0;
      stall = 1'b0;
      slow = 1'b0;
      RES_VALID = 1'b0;
      RES_LOOP = 1'b0;
      RES_TAKEN = 1'b0;
      repeat (16) @(negedge REF_CLK);
      chk("reset rows", 0, UOP_VALID);
      chk("reset ready", 1, GRP_READY);
      NRST = 1'b1;
      t_forms();
      t_cond();
      t_mode64();
      t_peak();
      t_ufuse();
      t_twoflow();
      t_loop();
      t_fill();
      close_out();
   end
endmodule
`default_nettype wire
